// [bench/btc_testbench.sv]
// self-checking testbench of the bcd time counter through its avalon register port
`timescale 1ns/1ps
`include "btc_defines.svh"
module testbench;
   import btc_pkg::*;

   // ***********************************************************
   // signals and design instance
   // ***********************************************************
   logic ref_clk_i;
   logic rstn_i;
   logic sleep_i;
   btc_avm_req_s avm_i;
   btc_avm_rsp_s avm_o;
   logic [1:0] sub_div_o;
   logic wake_medium_o;
   btc_mode_e mode_o;
   logic sec_flag_o;
   logic irq_o;
   int err_total;
   int total_checks;
   logic [7:0] rd;

   // short second period keeps the run small; 8 leaves room to disable ticks between two of them
   btc_top #(.SEC_CYCLES(8)) btc_top_i (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .avm_i(avm_i),
      .avm_o(avm_o),
      .sleep_i(sleep_i),
      .sub_div_o(sub_div_o),
      .wake_medium_o(wake_medium_o),
      .mode_o(mode_o),
      .sec_flag_o(sec_flag_o),
      .irq_o(irq_o)
   );

   // 200 mhz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one avalon transfer; request held until waitrequest is sampled low
   task bus(input logic [15:0] a, input logic wr, input logic [7:0] wd, output logic [7:0] rdv);
      int n;
      @(posedge ref_clk_i);
      avm_i.address <= a;
      avm_i.read <= ~wr;
      avm_i.write <= wr;
      avm_i.writedata <= {24'h000000, wd};
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (avm_o.waitrequest !== 1'b0 && n < 20);
      rdv = avm_o.readdata[7:0];
      avm_i.read <= 1'b0;
      avm_i.write <= 1'b0;
      if (n >= 20) begin
         err_total++;
         final_report();
      end
   endtask : bus

   task wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] v;
      bus(a, 1'b1, d, v);
   endtask : wr

   task rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] v;
      bus(a, 1'b0, 8'h00, v);
      check(what, {24'h000000, v}, {24'h000000, exp});
   endtask : rd_chk

   // ***********************************************************
   // scenarios
   // ***********************************************************
   // reset values of the time, sys1, sys2 and ie registers and an unmapped read
   task reset_case;
      check("wait idle", {31'h0, avm_o.waitrequest}, 32'h1);
      check("irq reset", {31'h0, irq_o}, 32'h0);
      check("mode reset", {29'h0, mode_o}, {29'h0, BTC_SLEEP});
      rd_chk("sec reset", `BTC_IDX_SEC, 8'h00);
      rd_chk("min reset", `BTC_IDX_MIN, 8'h00);
      rd_chk("hour reset", `BTC_IDX_HOUR, 8'h00);
      rd_chk("day reset", `BTC_IDX_DAY, 8'h00);
      rd_chk("sys1 reset", `BTC_IDX_SYS1, 8'h8c);
      rd_chk("sys2 reset", `BTC_IDX_SYS2, 8'h00);
      rd_chk("ie reset", `BTC_IDX_IE, 8'h80);
      wr(16'h0000, 8'h5a);
      rd_chk("unmapped", 16'h0000, 8'h00);
   endtask : reset_case

   // each mode choice and divider code; the divider output must wait for the sleep pulse
   task mode_case;
      logic [7:0] t1 [6] = '{8'h00, 8'h08, 8'h80, 8'h84, 8'h80, 8'h88};
      logic [7:0] t2 [6] = '{8'h00, 8'h05, 8'h02, 8'h07, 8'h08, 8'h0b};
      btc_mode_e tm [6] = '{BTC_SLEEP, BTC_SUBSLEEP, BTC_STANDBY, BTC_WATCH, BTC_DIRECT_ACT, BTC_DIRECT_SUB};
      logic [1:0] prev;
      prev = 2'b00;
      for (int i = 0; i < 6; i++) begin
         wr(`BTC_IDX_SYS1, t1[i]);
         wr(`BTC_IDX_SYS2, t2[i]);
         rd_chk("sys2 back", `BTC_IDX_SYS2, t2[i]);
         check("div before sleep", {30'h0, sub_div_o}, {30'h0, prev});
         @(posedge ref_clk_i);
         sleep_i <= 1'b1;
         @(posedge ref_clk_i);
         sleep_i <= 1'b0;
         @(posedge ref_clk_i);
         check("div after sleep", {30'h0, sub_div_o}, {30'h0, t2[i][1:0]});
         check("wake medium", {31'h0, wake_medium_o}, {31'h0, t2[i][2]});
         check("mode", {29'h0, mode_o}, {29'h0, tm[i]});
         prev = t2[i][1:0];
      end
   endtask : mode_case

   // load a time with ticks disabled, let exactly one enabled second pass, compare
   task step_case(input logic [7:0] s, m, h, d, mk, es, em, eh, ed, est);
      int n;
      wr(`BTC_IDX_IE, 8'h00);
      wr(`BTC_IDX_SEC, s);
      wr(`BTC_IDX_MIN, m);
      wr(`BTC_IDX_HOUR, h);
      wr(`BTC_IDX_DAY, d);
      wr(`BTC_IDX_MASK, mk);
      wr(`BTC_IDX_FLAG, 8'h00);
      bus(`BTC_IDX_STAT, 1'b0, 8'h00, rd);
      repeat (24) @(posedge ref_clk_i);
      rd_chk("sec held", `BTC_IDX_SEC, s);
      wr(`BTC_IDX_IE, 8'h80);
      n = 0;
      while (sec_flag_o !== 1'b1 && n < 50) begin
         @(posedge ref_clk_i);
         n++;
      end
      wr(`BTC_IDX_IE, 8'h00);
      if (n >= 50) begin
         err_total++;
         final_report();
      end
      check("irq level", {31'h0, irq_o}, {31'h0, |mk});
      rd_chk("sec step", `BTC_IDX_SEC, es);
      rd_chk("min step", `BTC_IDX_MIN, em);
      rd_chk("hour step", `BTC_IDX_HOUR, eh);
      rd_chk("day step", `BTC_IDX_DAY, ed);
      rd_chk("status", `BTC_IDX_STAT, est);
      rd_chk("status cleared", `BTC_IDX_STAT, 8'h00);
      check("irq cleared", {31'h0, irq_o}, 32'h0);
   endtask : step_case

   // flag clears only by writing 0; unused bit 7 of time bytes stays 0
   task flag_case;
      rd_chk("flag set", `BTC_IDX_FLAG, 8'h04);
      wr(`BTC_IDX_FLAG, 8'h04);
      rd_chk("flag kept", `BTC_IDX_FLAG, 8'h04);
      check("flag pin", {31'h0, sec_flag_o}, 32'h1);
      wr(`BTC_IDX_FLAG, 8'h00);
      rd_chk("flag clear", `BTC_IDX_FLAG, 8'h00);
      check("flag pin clr", {31'h0, sec_flag_o}, 32'h0);
      wr(`BTC_IDX_SEC, 8'hff);
      rd_chk("sec bit7", `BTC_IDX_SEC, 8'h7f);
      wr(`BTC_IDX_MIN, 8'hd5);
      rd_chk("min bit7", `BTC_IDX_MIN, 8'h55);
      // a write with the low byte lane off must leave the divider field alone
      avm_i.byteenable <= 4'he;
      wr(`BTC_IDX_SYS2, 8'h00);
      avm_i.byteenable <= 4'hf;
      rd_chk("lane refused", `BTC_IDX_SYS2, 8'h0b);
   endtask : flag_case

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      err_total = 0;
      total_checks = 0;
      rstn_i = 1'b0;
      sleep_i = 1'b0;
      avm_i = '0;
      avm_i.byteenable = 4'hf;
      repeat (20) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      reset_case();
      mode_case();
      step_case(8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01);
      step_case(8'h59, 8'h09, 8'h05, 8'h01, 8'h0f, 8'h00, 8'h10, 8'h05, 8'h01, 8'h03);
      step_case(8'h59, 8'h59, 8'h09, 8'h02, 8'h0f, 8'h00, 8'h00, 8'h10, 8'h02, 8'h07);
      step_case(8'h59, 8'h59, 8'h23, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0f);
      step_case(8'h59, 8'h59, 8'h23, 8'h06, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f);
      flag_case();
      final_report();
   end

endmodule : testbench

// [logic/btc_defines.svh]
// register offsets, field positions, reset values and timing counts of the bcd time counter
// Operation
// RULE1: medium speed flag picks medium or high speed active mode after wake
// RULE2: direct transfer flag at bit 3 joins the after-sleep mode choice
// RULE3: subactive clock field selects watch clock divided by 8, 4, 2 or 1
// RULE4: a new subactive clock setting applies only after the next sleep
// RULE5: rtc requests pass only while rtc irq enable, bit 7, is 1
// RULE6: seconds units count 0 to 9 and carry into seconds tens
// RULE7: seconds tens count 0 to 5; after 59 seconds return to 00
// RULE8: units in bits 3-0, tens in bits 6-4, bit 7 held 0
// RULE9: minutes units count 0 to 9 and carry into minutes tens
// RULE10: minutes tens count 0 to 5; after 59 minutes return to 00
// RULE11: hours kept as one bcd byte, weekday as one binary byte
// RULE12: hours tens count 0 to 2, hours in 24 hour form
// RULE13: one second flag set by event; cleared by writing 0 while 1
// RULE14: weekday code runs 000 sunday to 110 saturday, one step a day
// RULE15: minute wrap advances hours; hour wrap advances weekday, saturday to sunday
// RULE16: time bytes reset to zero; time advances only on enabled second events
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH

// ***********************************************************
// register indices (byte address is four times the index)
// ***********************************************************
`define BTC_IDX_SEC 16'hfb80
`define BTC_IDX_MIN 16'hfb81
`define BTC_IDX_HOUR 16'hfb82
`define BTC_IDX_DAY 16'hfb83
`define BTC_IDX_FLAG 16'hf067
`define BTC_IDX_MASK 16'hf068
`define BTC_IDX_STAT 16'hf069
`define BTC_IDX_SYS1 16'hfff0
`define BTC_IDX_SYS2 16'hfff1
`define BTC_IDX_IE 16'hfff3

// ***********************************************************
// field positions
// ***********************************************************
`define BTC_S1_STANDBY 7
`define BTC_S1_LOWSPD 3
`define BTC_S1_AUX 2
`define BTC_S2_DIRECT 3
`define BTC_S2_MEDIUM 2
`define BTC_S2_SUB_HI 1
`define BTC_S2_SUB_LO 0
`define BTC_IE_RTC 7
`define BTC_FLAG_SEC 2
`define BTC_EV_SEC 0
`define BTC_EV_MIN 1
`define BTC_EV_HOUR 2
`define BTC_EV_DAY 3

// ***********************************************************
// reset values and masks
// ***********************************************************
`define BTC_RST_SYS1 8'h8c
`define BTC_RST_SYS2 8'h00
`define BTC_RST_IE 8'h80
`define BTC_MSK_SYS1 8'h8c
`define BTC_MSK_SYS2 8'h0f
`define BTC_MSK_TIME 8'h7f
`define BTC_MSK_HOUR 8'h3f
`define BTC_MSK_DAY 8'h07
`define BTC_LAST_DAY 8'h06
`define BTC_LAST_HOUR 8'h23

// ***********************************************************
// timing
// ***********************************************************
`define BTC_CLK_PERIOD_NS 5
`define BTC_SEC_PERIOD_NS 1000000000
`define BTC_SEC_CYCLES (`BTC_SEC_PERIOD_NS / `BTC_CLK_PERIOD_NS)

`endif

// [logic/btc_digit.sv]
// one decimal digit step with wrap and carry
`timescale 1ns/1ps
module btc_digit #(
   parameter logic [3:0] MAX = 4'h9
) (
   input wire logic [3:0] val_i,
   input wire logic inc_i,
   output logic [3:0] next_o,
   output logic carry_o
);

   // wrap to zero past the top value and pass a carry on
   always_comb begin
      carry_o = inc_i && (val_i == MAX);
      if (!inc_i) begin
         next_o = val_i;
      end else if (carry_o) begin
         next_o = 4'h0;
      end else begin
         next_o = val_i + 4'h1;
      end
   end

endmodule : btc_digit

// [logic/btc_pkg.sv]
// types shared by the bcd time counter files
package btc_pkg;

   // mode entered after a sleep instruction
   typedef enum logic [2:0] {
      BTC_SLEEP = 3'b000,
      BTC_SUBSLEEP = 3'b001,
      BTC_STANDBY = 3'b010,
      BTC_WATCH = 3'b011,
      BTC_DIRECT_ACT = 3'b100,
      BTC_DIRECT_SUB = 3'b101
   } btc_mode_e;

   // avalon request from the master
   typedef struct packed {
      logic [15:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } btc_avm_req_s;

   // avalon answer to the master
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } btc_avm_rsp_s;

   // whole state of the top module
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] sys1;
      logic [7:0] sys2;
      logic [7:0] ie;
      logic flag;
      logic [3:0] status;
      logic [3:0] mask;
      logic irq;
      logic [1:0] sub_div;
      logic wake_medium;
      btc_mode_e mode;
      logic [31:0] div;
      logic tick;
      logic waitreq;
      logic [7:0] rdata;
   } btc_state_s;

endpackage : btc_pkg

// [logic/btc_top.sv]
// bcd time of day counter with sleep mode control and avalon register slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "btc_defines.svh"
module btc_top
   import btc_pkg::*;
#(
   parameter int SEC_CYCLES = `BTC_SEC_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire btc_avm_req_s avm_i,
   output btc_avm_rsp_s avm_o,
   input wire logic sleep_i,
   output logic [1:0] sub_div_o,
   output logic wake_medium_o,
   output btc_mode_e mode_o,
   output logic sec_flag_o,
   output logic irq_o
);

   // ***********************************************************
   // state
   // ***********************************************************
   btc_state_s st;
   btc_state_s next_st;

   // ***********************************************************
   // digit chain
   // ***********************************************************
   logic adv;
   logic [3:0] su_next;
   logic [3:0] st_next;
   logic [3:0] mu_next;
   logic [3:0] mt_next;
   logic su_carry;
   logic st_carry;
   logic mu_carry;
   logic mt_carry;

   // a second step only counts while rtc requests are enabled
   assign adv = st.tick && st.ie[`BTC_IE_RTC]; // RULE5 RULE16

   // seconds units, carry into tens
   btc_digit #(.MAX(4'h9)) u_sec_units ( // RULE6
      .val_i(st.sec[3:0]),
      .inc_i(adv),
      .next_o(su_next),
      .carry_o(su_carry)
   );

   // seconds tens wrap to zero after five
   btc_digit #(.MAX(4'h5)) u_sec_tens ( // RULE7
      .val_i({1'b0, st.sec[6:4]}),
      .inc_i(su_carry),
      .next_o(st_next),
      .carry_o(st_carry)
   );

   // minutes units advance once per minute
   btc_digit #(.MAX(4'h9)) u_min_units ( // RULE9
      .val_i(st.min[3:0]),
      .inc_i(st_carry),
      .next_o(mu_next),
      .carry_o(mu_carry)
   );

   // minutes tens wrap to zero after five
   btc_digit #(.MAX(4'h5)) u_min_tens ( // RULE10
      .val_i({1'b0, st.min[6:4]}),
      .inc_i(mu_carry),
      .next_o(mt_next),
      .carry_o(mt_carry)
   );

   // ***********************************************************
   // bus decode helpers
   // ***********************************************************
   logic req_new;
   logic wr_en;
   logic rd_en;
   logic wr_time;
   logic [7:0] wbyte;
   logic [7:0] rd_mux;
   logic [3:0] events;
   logic hour_wrap;

   // a request is taken once, in the cycle before waitrequest drops
   assign req_new = (avm_i.read || avm_i.write) && st.waitreq;
   assign wr_en = req_new && avm_i.write && avm_i.byteenable[0];
   assign rd_en = req_new && avm_i.read;
   assign wbyte = avm_i.writedata[7:0];
   assign wr_time = wr_en && (avm_i.address == `BTC_IDX_SEC || avm_i.address == `BTC_IDX_MIN ||
                              avm_i.address == `BTC_IDX_HOUR || avm_i.address == `BTC_IDX_DAY);
   assign hour_wrap = mt_carry && (st.hour == `BTC_LAST_HOUR);

   // read data mux; reserved bits and unmapped words read as zero
   always_comb begin
      case (avm_i.address)
         `BTC_IDX_SEC: rd_mux = st.sec;
         `BTC_IDX_MIN: rd_mux = st.min;
         `BTC_IDX_HOUR: rd_mux = st.hour;
         `BTC_IDX_DAY: rd_mux = st.day;
         `BTC_IDX_FLAG: rd_mux = {5'h00, st.flag, 2'h0};
         `BTC_IDX_MASK: rd_mux = {4'h0, st.mask};
         `BTC_IDX_STAT: rd_mux = {4'h0, st.status};
         `BTC_IDX_SYS1: rd_mux = st.sys1;
         `BTC_IDX_SYS2: rd_mux = st.sys2;
         `BTC_IDX_IE: rd_mux = st.ie;
         default: rd_mux = 8'h00;
      endcase
   end

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      next_st = st;
      events = 4'h0;

      // one second divider; the divide count is a parameter so tests can shorten it
      next_st.tick = 1'b0;
      if (st.div == 32'(SEC_CYCLES - 1)) begin
         next_st.div = 32'h0;
         next_st.tick = 1'b1;
      end else begin
         next_st.div = st.div + 32'h1;
      end

      // time bytes; bit 7 never set since only three tens bits are written
      next_st.sec = {1'b0, st_next[2:0], su_next}; // RULE8
      next_st.min = {1'b0, mt_next[2:0], mu_next}; // RULE8
      if (mt_carry) begin
         // hours follow the minute wrap in 24 hour form
         if (hour_wrap) begin
            next_st.hour = 8'h00; // RULE12 RULE15
            // weekday wraps saturday back to sunday
            if (st.day >= `BTC_LAST_DAY) begin
               next_st.day = 8'h00; // RULE14 RULE15
            end else begin
               next_st.day = st.day + 8'h01; // RULE11 RULE14
            end
         end else if (st.hour[3:0] == 4'h9) begin
            next_st.hour = {2'h0, st.hour[5:4] + 2'h1, 4'h0}; // RULE11 RULE12
         end else begin
            next_st.hour = {2'h0, st.hour[5:4], st.hour[3:0] + 4'h1}; // RULE15
         end
      end

      // events for the interrupt status
      events[`BTC_EV_SEC] = adv;
      events[`BTC_EV_MIN] = st_carry;
      events[`BTC_EV_HOUR] = mt_carry;
      events[`BTC_EV_DAY] = hour_wrap;

      // software writes win over the count step in the same cycle
      if (wr_en) begin
         case (avm_i.address)
            `BTC_IDX_SEC: next_st.sec = wbyte & `BTC_MSK_TIME; // RULE8
            `BTC_IDX_MIN: next_st.min = wbyte & `BTC_MSK_TIME; // RULE8
            `BTC_IDX_HOUR: next_st.hour = wbyte & `BTC_MSK_HOUR;
            `BTC_IDX_DAY: next_st.day = wbyte & `BTC_MSK_DAY;
            `BTC_IDX_MASK: next_st.mask = wbyte[3:0];
            `BTC_IDX_SYS1: next_st.sys1 = wbyte & `BTC_MSK_SYS1;
            `BTC_IDX_SYS2: next_st.sys2 = wbyte & `BTC_MSK_SYS2; // RULE2 RULE3
            `BTC_IDX_IE: next_st.ie = wbyte & 8'h80; // RULE5
            default: next_st.sys2 = st.sys2;
         endcase
      end

      // second flag: clear by writing 0 while it is 1, writing 1 does nothing, the event wins
      if (wr_en && avm_i.address == `BTC_IDX_FLAG && !wbyte[`BTC_FLAG_SEC] && st.flag) begin
         next_st.flag = 1'b0; // RULE13
      end
      if (adv) begin
         next_st.flag = 1'b1; // RULE13
      end

      // sticky status cleared by its read, new events kept over the clear
      if (rd_en && avm_i.address == `BTC_IDX_STAT) begin
         next_st.status = events;
      end else begin
         next_st.status = st.status | events;
      end
      next_st.irq = |(next_st.status & next_st.mask);

      // sleep latches the divider, the wake speed and the next mode
      if (sleep_i) begin
         next_st.sub_div = {st.sys2[`BTC_S2_SUB_HI], st.sys2[`BTC_S2_SUB_LO]}; // RULE3 RULE4
         next_st.wake_medium = st.sys2[`BTC_S2_MEDIUM]; // RULE1
         if (!st.sys1[`BTC_S1_STANDBY]) begin
            next_st.mode = st.sys1[`BTC_S1_LOWSPD] ? BTC_SUBSLEEP : BTC_SLEEP; // RULE2
         end else if (st.sys2[`BTC_S2_DIRECT]) begin
            next_st.mode = st.sys1[`BTC_S1_LOWSPD] ? BTC_DIRECT_SUB : BTC_DIRECT_ACT; // RULE2
         end else begin
            next_st.mode = st.sys1[`BTC_S1_AUX] ? BTC_WATCH : BTC_STANDBY; // RULE2
         end
      end

      // avalon answer: waitrequest drops for the one answering cycle
      next_st.waitreq = !req_new;
      if (rd_en) begin
         next_st.rdata = rd_mux;
      end
   end

   // ***********************************************************
   // state register
   // ***********************************************************
   // synchronous reset; the time bytes start at midnight sunday
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         st <= '0; // RULE16
         st.sys1 <= `BTC_RST_SYS1;
         st.sys2 <= `BTC_RST_SYS2;
         st.ie <= `BTC_RST_IE; // RULE5
         st.waitreq <= 1'b1;
         st.mode <= BTC_SLEEP;
      end else begin
         st <= next_st;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   // every output is a state field
   assign avm_o.readdata = {24'h000000, st.rdata};
   assign avm_o.waitrequest = st.waitreq;
   assign sub_div_o = st.sub_div; // RULE4
   assign wake_medium_o = st.wake_medium;
   assign mode_o = st.mode;
   assign sec_flag_o = st.flag;
   assign irq_o = st.irq;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   // the request cycle, then the answer cycle
   sequence s_req;
      (avm_i.read || avm_i.write) && avm_o.waitrequest;
   endsequence
   sequence s_answer;
      !avm_o.waitrequest ##1 avm_o.waitrequest;
   endsequence

   a_bus_answer: assert property (s_req |=> s_answer)
      else $error("bus answer not given in one cycle");
   a_bit7_zero: assert property (!st.sec[7] && !st.min[7]) // RULE8
      else $error("time byte bit 7 set");
   a_sec_step: assert property (adv && !wr_time && st.sec[3:0] != 4'h9 |=> // RULE6
      st.sec[3:0] == $past(st.sec[3:0]) + 4'h1 && st.sec[6:4] == $past(st.sec[6:4]))
      else $error("seconds units did not step");
   a_sec_wrap: assert property (adv && !wr_time && st.sec == 8'h59 |=> st.sec == 8'h00) // RULE7
      else $error("seconds did not wrap");
   a_min_carry: assert property (adv && !wr_time && st.sec == 8'h59 && st.min == 8'h29 |=> // RULE9
      st.min == 8'h30)
      else $error("minutes carry wrong");
   a_min_wrap: assert property (adv && !wr_time && st.sec == 8'h59 && st.min == 8'h59 |=> // RULE10
      st.min == 8'h00)
      else $error("minutes did not wrap");
   a_hour_day: assert property (adv && !wr_time && st.sec == 8'h59 && st.min == 8'h59 && // RULE15
      st.hour == 8'h23 && st.day == 8'h06 |=> st.hour == 8'h00 && st.day == 8'h00)
      else $error("hour or weekday wrap wrong");
   a_day_range: assert property (st.day <= 8'h06 && st.hour[5:4] <= 2'h2) // RULE14
      else $error("weekday or hour tens out of range");
   a_tick_gated: assert property (st.tick && !st.ie[`BTC_IE_RTC] && !wr_time |=> $stable(st.sec)) // RULE16
      else $error("time moved while disabled");
   a_flag_set: assert property (adv |=> st.flag) // RULE13
      else $error("second flag not set");
   a_div_hold: assert property (!sleep_i |=> $stable(sub_div_o)) // RULE4
      else $error("divider changed without sleep");
   a_wake_speed: assert property (sleep_i |=> wake_medium_o == $past(st.sys2[`BTC_S2_MEDIUM])) // RULE1
      else $error("wake speed not latched");

   // flag clear and flag keep: writing 0 clears a set flag unless a second lands, writing 1 is ignored
   sequence s_flag_wr;
      wr_en && avm_i.address == `BTC_IDX_FLAG && st.flag;
   endsequence
   a_flag_clear: assert property (s_flag_wr ##0 (!wbyte[`BTC_FLAG_SEC] && !adv) |=> !st.flag) // RULE13
      else $error("second flag not cleared by a zero write");
   a_flag_kept: assert property (s_flag_wr ##0 wbyte[`BTC_FLAG_SEC] |=> st.flag) // RULE13
      else $error("second flag cleared by a one write");

   // the interrupt level always follows the registered status under its mask
   a_irq_level: assert property (irq_o == |(st.status & st.mask)) // RULE5
      else $error("irq level does not match masked status");

   // status bits stay set until their register is read
   a_status_sticky: assert property (!(rd_en && avm_i.address == `BTC_IDX_STAT) |=>
      (st.status & $past(st.status)) == $past(st.status))
      else $error("status bit lost without a read");

   // the mode output only moves on a sleep instruction
   a_mode_hold: assert property (!sleep_i |=> $stable(mode_o)) // RULE2
      else $error("mode changed without sleep");
   a_mode_sleep: assert property (sleep_i && !st.sys1[`BTC_S1_STANDBY] && !st.sys1[`BTC_S1_LOWSPD] |=> // RULE2
      mode_o == BTC_SLEEP)
      else $error("plain sleep mode not chosen");
   a_mode_watch: assert property (sleep_i && st.sys1[`BTC_S1_STANDBY] && !st.sys2[`BTC_S2_DIRECT] && // RULE2
      st.sys1[`BTC_S1_AUX] |=> mode_o == BTC_WATCH)
      else $error("watch mode not chosen");

   // the hours units carry into the hours tens at nine
   a_hour_carry: assert property (mt_carry && !wr_time && st.hour == 8'h09 |=> st.hour == 8'h10) // RULE12
      else $error("hours tens carry wrong");

   // a write without its low byte lane enabled changes no control register
   a_lane_refused: assert property (req_new && avm_i.write && !avm_i.byteenable[0] |=>
      $stable(st.sys2) && $stable(st.sys1) && $stable(st.ie))
      else $error("write without byte lane took effect");

endmodule : btc_top
